// *** src/qpc_pkg.sv ***
// Shared constants and types for the quadrature position counter.
package qpc_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int          POS_W        = 32;
  localparam int          REG_W        = 32;
  localparam int          ADDR_W       = 4;
  localparam logic [31:0] POS_RST      = 32'h0000_0000;
  localparam logic [31:0] MAX_RST      = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_POS     = 32'h0000_0000;

  // ==========================================================================
  // Register offsets (full 4-bit addresses, one word each)
  // ==========================================================================
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_MAX      = 4'h4;
  localparam logic [3:0]  OFS_INIT     = 4'h8;
  localparam logic [3:0]  OFS_POS      = 4'hC;
  localparam logic [3:0]  OFS_STAT     = 4'h1;
  localparam logic [3:0]  OFS_IRQ_EN   = 4'h2;
  localparam logic [3:0]  OFS_IRQ_CLR  = 4'h3;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int          CTL_SWAP     = 0;
  localparam int          CTL_MODE_LO  = 1;
  localparam int          CTL_LOAD     = 3;
  localparam logic [2:0]  CTRL_RST     = 3'h0;

  // Interrupt status bit positions.
  localparam int          IRQ_OVF      = 0;
  localparam int          IRQ_UNF      = 1;
  localparam int          IRQ_IDX      = 2;
  localparam int          IRQ_W        = 3;

  // Counter reset policies, as coded in the control register.
  typedef enum logic [1:0] {
    QPC_POL_INDEX       = 2'h0,
    QPC_POL_MAX         = 2'h1,
    QPC_POL_FIRST_INDEX = 2'h2
  } qpc_policy_t;

endpackage : qpc_pkg

// *** src/qpc_decoder.sv ***
// Quadrature decoder: input sync, swap, count pulse and direction.
module qpc_decoder (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Encoder pins
  input  wire logic track_a_in,
  input  wire logic track_b_in,
  input  wire logic index_in,
  // Control
  input  wire logic swap,
  // Decoded outputs
  output logic      count_pulse,
  output logic      direction_flag,
  output logic      index_edge
);

  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] prev_r;
  logic       decoder_input_a;
  logic       decoder_input_b;
  logic       pa;
  logic       pb;
  logic       step;

  // Two-stage synchronisers; stage one is read only by stage two.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {index_in, track_b_in, track_a_in};
      s2_r <= s1_r;
    end
  end

  assign decoder_input_a = swap ? s2_r[1] : s2_r[0];
  assign decoder_input_b = swap ? s2_r[0] : s2_r[1];
  assign pa              = swap ? prev_r[1] : prev_r[0];
  assign pb              = swap ? prev_r[0] : prev_r[1];

  // any track edge; gives four per cycle.
  assign step = (decoder_input_a ^ pa) | (decoder_input_b ^ pb);

  // History of the synchronised levels for edge detection.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prev_r <= 3'h0;
    end else begin
      prev_r <= s2_r;
    end
  end

  // Registered pulse and direction; a double edge keeps the old sense.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_pulse    <= 1'b0;
      direction_flag <= 1'b1;
      index_edge     <= 1'b0;
    end else begin
      count_pulse <= step;
      index_edge  <= s2_r[2] ^ prev_r[2];
      if (step && ((decoder_input_a ^ pa) ^ (decoder_input_b ^ pb))) begin
        direction_flag <= (decoder_input_a ^ pa) ? (decoder_input_a ^ decoder_input_b)
                                                 : ~(decoder_input_a ^ decoder_input_b);
      end
    end
  end

endmodule : qpc_decoder

// *** src/qpc_top.sv ***
// Quadrature position counter: decoder, position counter, registers, interrupt.
module qpc_top (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  // Encoder pins
  input  wire logic                        track_a_in,
  input  wire logic                        track_b_in,
  input  wire logic                        index_in,
  // Register port
  input  wire logic [qpc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [qpc_pkg::REG_W-1:0]   reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [qpc_pkg::REG_W-1:0]   reg_rdata,
  // Status outputs
  output logic      [qpc_pkg::POS_W-1:0]   position_count,
  output logic                             direction_flag,
  output logic                             first_index_marker_flag,
  output logic                             phase_error_flag,
  output logic                             irq
);

  // ==========================================================================
  // Registers and wires
  // ==========================================================================
  logic [2:0]                 decoder_control_r;
  logic [qpc_pkg::POS_W-1:0]  max_position_r;
  logic [qpc_pkg::POS_W-1:0]  initial_position_r;
  logic [qpc_pkg::IRQ_W-1:0]  decoder_status_r;
  logic [qpc_pkg::IRQ_W-1:0]  irq_en_r;
  logic [qpc_pkg::POS_W-1:0]  position_nxt;
  logic                       count_pulse;
  logic                       dir_w;
  logic                       index_edge;
  logic                       ovf_ev;
  logic                       unf_ev;
  logic                       idx_reset;
  logic                       load_init;
  logic [1:0]                 policy;
  logic [qpc_pkg::IRQ_W-1:0]  irq_clr;

  assign policy = decoder_control_r[qpc_pkg::CTL_MODE_LO +: 2];

  // ==========================================================================
  // Decoder
  // ==========================================================================
  // quadrature mode only
  qpc_decoder u_dec (
    .ref_clk        (ref_clk),
    .nrst           (nrst),
    .track_a_in     (track_a_in),
    .track_b_in     (track_b_in),
    .index_in       (index_in),
    .swap           (decoder_control_r[qpc_pkg::CTL_SWAP]),
    .count_pulse    (count_pulse),
    .direction_flag (dir_w),
    .index_edge     (index_edge)
  );

  // ==========================================================================
  // Position counter
  // ==========================================================================
  // Index reset applies in the index policy always, and once in first-index.
  // every index edge resets in the index policy, only the first in first-index
  assign idx_reset = index_edge &&
                     ((policy == 2'(qpc_pkg::QPC_POL_INDEX)) ||
                      ((policy == 2'(qpc_pkg::QPC_POL_FIRST_INDEX)) &&
                       !first_index_marker_flag));

  // A software write of the load bit copies the initial value.
  assign load_init = reg_wr && (reg_addr == qpc_pkg::OFS_CTRL) &&
                     reg_wdata[qpc_pkg::CTL_LOAD];

  // Next count; wrap events are flagged for the status register.
  always_comb begin
    position_nxt = position_count;
    ovf_ev       = 1'b0;
    unf_ev       = 1'b0;
    if (load_init) begin
      // Initial value is trusted to lie in range.
      position_nxt = initial_position_r;
    end else if (idx_reset) begin
      position_nxt = dir_w ? qpc_pkg::ZERO_POS : max_position_r;
    end else if (count_pulse) begin
      if (dir_w) begin
        if (position_count >= max_position_r) begin
          position_nxt = qpc_pkg::ZERO_POS;
          ovf_ev       = 1'b1;
        end else begin
          position_nxt = position_count + 32'h0000_0001;
        end
      end else begin
        if (position_count == qpc_pkg::ZERO_POS) begin
          position_nxt = max_position_r;
          unf_ev       = 1'b1;
        end else begin
          position_nxt = position_count - 32'h0000_0001;
        end
      end
    end
  end

  // Position register.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      position_count <= qpc_pkg::POS_RST;
    end else begin
      position_count <= position_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      direction_flag <= 1'b1;
    end else begin
      direction_flag <= dir_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      first_index_marker_flag <= 1'b0;
    end else if (index_edge) begin
      first_index_marker_flag <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      phase_error_flag <= 1'b0;
    end else begin
      phase_error_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Register port
  // ==========================================================================
  assign irq_clr = (reg_wr && (reg_addr == qpc_pkg::OFS_IRQ_CLR)) ?
                   reg_wdata[qpc_pkg::IRQ_W-1:0] : 3'h0;

  // Software-written configuration registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      decoder_control_r  <= qpc_pkg::CTRL_RST;
      max_position_r     <= qpc_pkg::MAX_RST;
      initial_position_r <= qpc_pkg::POS_RST;
      irq_en_r           <= 3'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        qpc_pkg::OFS_CTRL:   decoder_control_r  <= reg_wdata[2:0];
        qpc_pkg::OFS_MAX:    max_position_r     <= reg_wdata;
        qpc_pkg::OFS_INIT:   initial_position_r <= reg_wdata;
        qpc_pkg::OFS_IRQ_EN: irq_en_r           <= reg_wdata[qpc_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status; a new event beats a clear in the same cycle.
  // overflow, underflow and index flags
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      decoder_status_r <= 3'h0;
    end else begin
      decoder_status_r <= (decoder_status_r & ~irq_clr) |
                          {idx_reset, unf_ev, ovf_ev};
    end
  end

  // Level interrupt while any enabled status bit is set.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((decoder_status_r & ~irq_clr) | {idx_reset, unf_ev, ovf_ev}) & irq_en_r);
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        qpc_pkg::OFS_CTRL:   reg_rdata <= {29'h0, decoder_control_r};
        qpc_pkg::OFS_MAX:    reg_rdata <= max_position_r;
        qpc_pkg::OFS_INIT:   reg_rdata <= initial_position_r;
        qpc_pkg::OFS_POS:    reg_rdata <= position_count;
        qpc_pkg::OFS_STAT:   reg_rdata <= {27'h0, first_index_marker_flag,
                                           direction_flag, decoder_status_r};
        qpc_pkg::OFS_IRQ_EN: reg_rdata <= {29'h0, irq_en_r};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : qpc_top

// *** verif/qpc_asserts.sv ***
// Port-level checker for the quadrature position counter.
module qpc_asserts (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Stimulus seen at the inputs
  input wire logic        index_in,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  // Results seen at the outputs
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] position_count,
  input wire logic        direction_flag,
  input wire logic        first_index_marker_flag,
  input wire logic        phase_error_flag,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] max_r;
  logic [2:0]  en_r;
  logic [1:0]  pol_r;
  logic        idx_r;
  logic [3:0]  quiet_r;
  logic        q;

  // ==========================================================================
  // Shadow state
  // ==========================================================================
  // The checker sees only ports, so it keeps its own copy of the settings.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      max_r <= qpc_pkg::MAX_RST;
      en_r  <= 3'h0;
      pol_r <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == qpc_pkg::OFS_MAX) max_r <= reg_wdata;
      if (reg_addr == qpc_pkg::OFS_IRQ_EN) en_r <= reg_wdata[2:0];
      if (reg_addr == qpc_pkg::OFS_CTRL) pol_r <= reg_wdata[2:1];
    end
  end

  // Calm cycles only: an index edge or a write may move the counter freely.
  always_ff @(posedge ref_clk) begin
    idx_r <= index_in;
    if (!nrst || reg_wr || index_in != idx_r) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  assign q = (quiet_r == 4'hF);

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_mid;
    q && $changed(position_count) && $past(position_count) != max_r
      && $past(position_count) != 32'h0;
  endsequence
  sequence s_wrap_up;
    q && $changed(position_count) && $past(position_count) == max_r && direction_flag;
  endsequence
  sequence s_wrap_dn;
    q && $changed(position_count) && $past(position_count) == 32'h0 && !direction_flag;
  endsequence
  sequence s_idx(d);
    index_in != idx_r && pol_r == 2'h0 && direction_flag == d;
  endsequence

  a_phase_quiet: assert property (phase_error_flag == 1'b0)
    else $error("phase error flag raised");
  a_fim_sticky: assert property (first_index_marker_flag |=> first_index_marker_flag)
    else $error("first index flag dropped");
  a_step_one: assert property (s_mid |->
    position_count == $past(position_count) + 32'h1
    || position_count == $past(position_count) - 32'h1)
    else $error("counter moved by more than one");
  a_step_dir: assert property (s_mid |->
    direction_flag == (position_count == $past(position_count) + 32'h1))
    else $error("count sense differs from direction");
  a_ovf_zero: assert property (s_wrap_up |-> position_count == 32'h0)
    else $error("overflow did not load zero");
  a_unf_max: assert property (s_wrap_dn |-> position_count == max_r)
    else $error("underflow did not load maximum");
  a_irq_ovf: assert property (s_wrap_up ##0 en_r[qpc_pkg::IRQ_OVF] |-> ##[1:2] irq)
    else $error("overflow raised no interrupt");
  a_idx_fwd: assert property (s_idx(1'b1) |-> ##[2:8] position_count == 32'h0)
    else $error("forward index did not clear");
  a_idx_rev: assert property (s_idx(1'b0) |-> ##[2:8] position_count == max_r)
    else $error("reverse index did not load maximum");
  // A status read returns the flags as they stood at the strobe.
  a_stat_read: assert property ($past(reg_rd) && $past(reg_addr) == qpc_pkg::OFS_STAT |->
    reg_rdata[4:3] == {$past(first_index_marker_flag), $past(direction_flag)})
    else $error("status read differs from flag outputs");
endmodule : qpc_asserts

bind qpc_top qpc_asserts chk_u (.ref_clk, .nrst, .index_in, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .position_count, .direction_flag, .first_index_marker_flag,
  .phase_error_flag, .irq);

// *** verif/qpc_encoder_model.sv ***
// Behavioural incremental encoder with two quadrature tracks and an index track.
module qpc_encoder_model (
  // Clock
  input  wire logic ref_clk,
  // Encoder tracks
  output logic      track_a_in,
  output logic      track_b_in,
  output logic      index_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;

  // Start at rest, phase zero, index low.
  initial begin
    track_a_in = 1'b0;
    track_b_in = 1'b0;
    index_in = 1'b0;
  end

  // ideal Gray tracks
  // k Gray steps per call, six cycles apart so that no two edges can merge.
  task automatic move(input int d, input int k);
    for (int i = 0; i < k; i++) begin
      repeat (6) @(posedge ref_clk);
      ph = (ph + (d != 0 ? 1 : 3)) % 4;
      track_a_in <= (ph == 1 || ph == 2);
      track_b_in <= (ph >= 2);
    end
  endtask : move

  // Drives the index track to a new level just after an edge.
  task automatic mark(input logic v);
    @(posedge ref_clk);
    index_in <= v;
  endtask : mark
endmodule : qpc_encoder_model

// *** verif/test_quadrature_position_counter.sv ***
// Self-checking bench for the quadrature position counter.
module test_quadrature_position_counter;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, position_count;
  logic        track_a_in, track_b_in, index_in, direction_flag;
  logic        first_index_marker_flag, phase_error_flag, irq;
  int          bad_count = 0;
  int          samples_checked = 0;
  int unsigned pos, mx;
  int          st, dir, fim, pol, swp, en;

  // 25 MHz clock.
  always #20 ref_clk = ~ref_clk;

  qpc_encoder_model enc_u (.ref_clk, .track_a_in, .track_b_in, .index_in);
  qpc_top dut_u (.ref_clk, .nrst, .track_a_in, .track_b_in, .index_in, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .position_count, .direction_flag,
    .first_index_marker_flag, .phase_error_flag, .irq);

  // ==========================================================================
  // Checking and register tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rdc

  task automatic rds();
    rdc(4'h1, st | (dir << 3) | (fim << 4));
  endtask : rds

  task automatic rst();
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    mx = 32'hFFFFFFFF;
    dir = 1;
    {pos, st, fim, pol, swp, en} = '0;
  endtask : rst

  // ==========================================================================
  // Reference model steps
  // ==========================================================================
  task automatic cfg(input int p, input int s, input int unsigned m, input int unsigned i);
    pol = p;
    swp = s;
    mx = m;
    pos = i;
    wr(4'h4, m);
    wr(4'h8, i);
    wr(4'h0, (p << 1) | s | 8);
    rdc(4'h0, (p << 1) | s);
    rdc(4'h4, m);
  endtask : cfg

  task automatic mv(input int d, input int k);
    enc_u.move(d, k);
    for (int i = 0; i < k; i++) begin
      dir = d ^ swp;
      st = st | (dir == 1 && pos >= mx) | ((dir == 0 && pos == 0) << 1);
      pos = dir == 1 ? (pos >= mx ? 0 : pos + 1) : (pos == 0 ? mx : pos - 1);
    end
    repeat (8) @(posedge ref_clk);
    chk(position_count, pos);
    chk(direction_flag, dir);
    chk(irq, |(st & en));
  endtask : mv

  task automatic ix(input logic v);
    enc_u.mark(v);
    if (pol == 0 || (pol == 2 && fim == 0)) begin
      pos = dir == 1 ? 0 : mx;
      st = st | 4;
    end
    fim = 1;
    repeat (8) @(posedge ref_clk);
    chk(position_count, pos);
    chk(first_index_marker_flag, 1'b1);
  endtask : ix

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(32'hff51af34));
    rst();
    rdc(4'h0, 32'h0);
    rdc(4'h4, 32'hFFFFFFFF);
    rdc(4'hC, 32'h0);
    rds();
    rdc(4'hF, 32'h0);
    chk(phase_error_flag, 1'b0);
    $display("reset values done");
    en = 7;
    wr(4'h2, 7);
    cfg(1, 0, 4, $urandom_range(4));
    mv(1, 6 + $urandom_range(5));
    rds();
    wr(4'h3, 7);
    st = 0;
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    mv(0, 9 + $urandom_range(4));
    rds();
    en = 2;
    wr(4'h2, 2);
    wr(4'h3, 7);
    st = 0;
    mv(1, 5);
    $display("wrap policy done");
    cfg(1, 1, 7, 3);
    mv(1, 4 + $urandom_range(3));
    wr(4'hC, 32'h5A);
    rdc(4'hC, pos);
    rds();
    $display("swap done");
    // sixteen counts fit a whole revolution
    cfg(0, 0, 15, 0);
    mv(1, 5);
    ix(1'b1);
    mv(0, 3);
    ix(1'b0);
    rds();
    mv(0, enc_u.ph);
    $display("index policy done");
    rst();
    rds();
    cfg(2, 0, 9, 2);
    mv(1, 3);
    ix(1'b1);
    mv(1, 2);
    ix(1'b0);
    mv(1, 9);
    rds();
    $display("first index policy done");
    complete_run();
  end

  // Guard against a hang anywhere in the sequence.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end
endmodule : test_quadrature_position_counter
